// ---- rtl/i2c_link_defs.svh ----
// Function
// - Works at 100k, 400k and 1M bit rates
// - Only 7-bit addressing, no 10-bit response
// - General call 0x00 then 0x06 resets device
// - Reset pulses at ack rise after byte two
// - Start is data fall while clock high
// - Stop is data rise, target releases bus
// - Data stable while clock high, sampled there
// - Eight bits MSB first plus one ack
// - Acknowledge the address only on match
// - Ack holds data low on ninth clock
// - Receiver acknowledges each byte except the last read byte
// - Controller makes clocks, conditions and address
// - Update is four acked bytes, 36 clocks
// - Command byte selects target of data
// - Update at fall ending lower byte ack
// - Address upper nibble is fixed 1001
// - Select pin picks low three address bits
// - Select pin sampled during every first byte
// - Broadcast address 1000111 acknowledged on every write
// - Broadcast only in write direction
// - First protocol seen locks interface type
// - Read returns upper then lower data byte
`ifndef I2C_LINK_DEFS_SVH
`define I2C_LINK_DEFS_SVH
`define ADDR_PREFIX 4'h9
`define BCAST_ADDR 7'h47
`define GCALL_ADDR 7'h00
`define GCALL_RESET 8'h06
`define ACK_BIT 4'h8
`define LAST_DATA_BIT 4'h7
`define ASEL_GND 3'h0
`define ASEL_VDD 3'h1
`define ASEL_SDA 3'h2
`define ASEL_SCL 3'h3
`define BYTE_CMD 3'h1
`define BYTE_UPPER 3'h2
`define BYTE_LOWER 3'h3
`define SYS_CLK_HZ 50000000
`define BIT_RATE_HZ 100000
`define QTR_CYCLES (`SYS_CLK_HZ / (4 * `BIT_RATE_HZ))
`endif

// ---- rtl/i2c_link_pkg.sv ----
package i2c_link_pkg;
  typedef enum logic [2:0] {st_idle, st_addr, st_write, st_read, st_ignore} tgt_state_t;
  typedef enum logic [1:0] {lk_none, lk_i2c, lk_other} proto_lock_t;
  typedef enum logic [1:0] {c_idle, c_start, c_bit, c_stop} ctl_state_t;
  typedef enum logic [1:0] {op_write, op_read, op_gcall} ctl_op_t;
endpackage

// ---- rtl/i2c_link_if.sv ----
`timescale 1ns/100ps
interface i2c_link_if;
  logic ctl_scl_oe;
  logic ctl_sda_oe;
  logic tgt_sda_oe;
  logic scl;
  logic sda;
  // Open-drain wires with pullups: any enable pulls the line low
  assign scl = ~ctl_scl_oe;
  assign sda = ~(ctl_sda_oe | tgt_sda_oe);
  modport tgt(input scl, input sda, output tgt_sda_oe);
  modport ctl(input scl, input sda, output ctl_scl_oe, output ctl_sda_oe);
endinterface

// ---- rtl/i2c_target_port.sv ----
`timescale 1ns/100ps
`include "i2c_link_defs.svh"
module i2c_target_port import i2c_link_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Bus side
  i2c_link_if.tgt link,
  // Address select pin and protocol detect
  input wire logic addr_select_pin,
  input wire logic other_proto_seen,
  // Readback word for the current command
  input wire logic [15:0] read_data,
  // Update and reset outputs
  output logic update_pulse,
  output logic [7:0] command,
  output logic [15:0] data_word,
  output logic sw_reset
);
  // ----------------------------------------
  // Pin synchronisers and condition detect
  // ----------------------------------------
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [1:0] pin_sync;
  logic scl_prev;
  logic sda_prev;
  logic scl_s;
  logic sda_s;
  logic pin_s;
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;

  // Two stages before any logic reads the pins
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      pin_sync <= 2'h0;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], link.scl};
      sda_sync <= {sda_sync[0], link.sda};
      pin_sync <= {pin_sync[0], addr_select_pin};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  assign scl_s = scl_sync[1];
  assign sda_s = sda_sync[1];
  assign pin_s = pin_sync[1];
  // Sampling at system rate covers every supported bit rate
  assign start_det = scl_s & scl_prev & sda_prev & ~sda_s;
  assign stop_det = scl_s & scl_prev & ~sda_prev & sda_s;
  assign scl_rise = scl_s & ~scl_prev;
  assign scl_fall = ~scl_s & scl_prev;

  // ----------------------------------------
  // Protocol lock
  // ----------------------------------------
  proto_lock_t lock;

  // Whichever protocol talks first owns the part until rst_n is next asserted
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock <= lk_none;
    end else if (lock == lk_none) begin
      if (start_det) begin
        lock <= lk_i2c;
      end else if (other_proto_seen) begin
        lock <= lk_other;
      end
    end
  end

  // ----------------------------------------
  // Address select pin decode
  // ----------------------------------------
  tgt_state_t state;
  logic [3:0] bit_cnt;
  logic pin_hi;
  logic pin_ne_sda;
  logic pin_ne_scl;
  logic [2:0] asel;
  logic [6:0] own_addr;

  // Compare the pin with both bus lines over the first byte of each frame
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_hi <= 1'b0;
      pin_ne_sda <= 1'b0;
      pin_ne_scl <= 1'b0;
    end else if (start_det) begin
      pin_hi <= 1'b0;
      pin_ne_sda <= 1'b0;
      pin_ne_scl <= 1'b0;
    end else if (state == st_addr && bit_cnt < `ACK_BIT) begin
      pin_hi <= pin_hi | pin_s;
      pin_ne_sda <= pin_ne_sda | (pin_s ^ sda_s);
      pin_ne_scl <= pin_ne_scl | (pin_s ^ scl_s);
    end
  end

  // Clock line toggles in every byte, so it is told apart first
  always_comb begin
    if (!pin_ne_scl) begin
      asel = `ASEL_SCL;
    end else if (!pin_ne_sda) begin
      asel = `ASEL_SDA;
    end else if (pin_hi) begin
      asel = `ASEL_VDD;
    end else begin
      asel = `ASEL_GND;
    end
  end

  assign own_addr = {`ADDR_PREFIX, asel};

  // ----------------------------------------
  // Frame engine
  // ----------------------------------------
  logic [7:0] shreg;
  logic [7:0] tx_reg;
  logic [7:0] upper_data_byte;
  logic [2:0] byte_cnt;
  logic gcall;
  logic host_nack;
  logic match;
  logic first_fall;

  // Ten-bit headers start 11110 and can never match these addresses
  assign match = (shreg[7:1] == own_addr)
    | (shreg[7:1] == `BCAST_ADDR && !shreg[0])
    | (shreg[7:1] == `GCALL_ADDR && !shreg[0]);

  // Bit, byte and ack sequencing; stop or start drops any partial frame
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= st_idle;
      bit_cnt <= 4'h0;
      byte_cnt <= 3'h0;
      shreg <= 8'h00;
      tx_reg <= 8'h00;
      upper_data_byte <= 8'h00;
      gcall <= 1'b0;
      host_nack <= 1'b0;
      link.tgt_sda_oe <= 1'b0;
      update_pulse <= 1'b0;
      sw_reset <= 1'b0;
      command <= 8'h00;
      data_word <= 16'h0000;
      first_fall <= 1'b0;
    end else begin
      update_pulse <= 1'b0;
      sw_reset <= 1'b0;
      if (stop_det) begin
        state <= st_idle;
        link.tgt_sda_oe <= 1'b0;
      end else if (start_det && lock != lk_other) begin
        state <= st_addr;
        bit_cnt <= 4'h0;
        first_fall <= 1'b1;
        byte_cnt <= 3'h0;
        gcall <= 1'b0;
        host_nack <= 1'b0;
        link.tgt_sda_oe <= 1'b0;
      end else if (state != st_idle && state != st_ignore) begin
        if (scl_rise) begin
          if (bit_cnt < `ACK_BIT) begin
            shreg <= {shreg[6:0], sda_s};
          end else if (state == st_read) begin
            host_nack <= sda_s;
          end else if (state == st_write && gcall && byte_cnt == `BYTE_CMD
                       && shreg == `GCALL_RESET) begin
            sw_reset <= 1'b1;
          end
        end
        // Fall that closes a start condition carries no bit, so it must not advance the count
        if (scl_fall && first_fall) begin
          first_fall <= 1'b0;
        end else if (scl_fall) begin
          if (bit_cnt == `LAST_DATA_BIT) begin
            bit_cnt <= `ACK_BIT;
            if (state == st_addr) begin
              if (match) begin
                link.tgt_sda_oe <= 1'b1;
                gcall <= (shreg[7:1] == `GCALL_ADDR);
              end else begin
                state <= st_ignore;
              end
            end else if (state == st_write) begin
              link.tgt_sda_oe <= 1'b1;
              if (!gcall && byte_cnt == `BYTE_CMD) begin
                command <= shreg;
              end
              if (byte_cnt == `BYTE_UPPER) begin
                upper_data_byte <= shreg;
              end
            end else begin
              link.tgt_sda_oe <= 1'b0;
            end
          end else if (bit_cnt == `ACK_BIT) begin
            bit_cnt <= 4'h0;
            link.tgt_sda_oe <= 1'b0;
            byte_cnt <= byte_cnt + 3'h1;
            if (state == st_addr) begin
              state <= shreg[0] ? st_read : st_write;
              if (shreg[0]) begin
                tx_reg <= {read_data[14:8], 1'b0};
                link.tgt_sda_oe <= ~read_data[15];
              end
            end else if (state == st_write) begin
              if (!gcall && byte_cnt == `BYTE_LOWER) begin
                update_pulse <= 1'b1;
                data_word <= {upper_data_byte, shreg};
                byte_cnt <= `BYTE_CMD;
              end
            end else if (!host_nack && byte_cnt == `BYTE_CMD) begin
              tx_reg <= {read_data[6:0], 1'b0};
              link.tgt_sda_oe <= ~read_data[7];
            end else begin
              state <= st_ignore;
            end
          end else begin
            bit_cnt <= bit_cnt + 4'h1;
            if (state == st_read) begin
              link.tgt_sda_oe <= ~tx_reg[7];
              tx_reg <= {tx_reg[6:0], 1'b0};
            end
          end
        end
      end
    end
  end
endmodule

// ---- rtl/i2c_bus_controller.sv ----
`timescale 1ns/100ps
`include "i2c_link_defs.svh"
module i2c_bus_controller import i2c_link_pkg::*; #(
  parameter int QTR = `QTR_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Bus side
  i2c_link_if.ctl link,
  // Request
  input wire logic req,
  input wire ctl_op_t op,
  input wire logic [6:0] target_addr,
  input wire logic [7:0] cmd_byte,
  input wire logic [15:0] wdata,
  // Status and readback
  output logic busy,
  output logic done,
  output logic ack_err,
  output logic [15:0] rdata
);
  // ----------------------------------------
  // Quarter-bit divider and data sync
  // ----------------------------------------
  logic [15:0] div;
  logic tick;
  logic [1:0] sda_sync;

  // The controller owns the bit clock, so it is derived here
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div <= 16'h0000;
      tick <= 1'b0;
    end else begin
      tick <= (div == 16'(QTR - 1));
      div <= (div == 16'(QTR - 1)) ? 16'h0000 : div + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_sync <= 2'h3;
    end else begin
      sda_sync <= {sda_sync[0], link.sda};
    end
  end

  // ----------------------------------------
  // Byte sequencer
  // ----------------------------------------
  ctl_state_t state;
  ctl_op_t op_q;
  logic [6:0] addr_q;
  logic [7:0] cmd_q;
  logic [15:0] wdata_q;
  logic [1:0] phase;
  logic [3:0] bit_cnt;
  logic [2:0] idx;
  logic [2:0] n_bytes;
  logic [7:0] txb;
  logic [7:0] shreg;
  logic nack;
  logic is_rx;
  logic [7:0] cur_byte;

  // Reads: address+W, command, repeated start, address+R, two rx bytes
  always_comb begin
    is_rx = (op_q == op_read) && (idx >= `BYTE_LOWER);
    case (idx)
      3'h0: cur_byte = (op_q == op_gcall) ? {`GCALL_ADDR, 1'b0} : {addr_q, 1'b0};
      3'h1: cur_byte = (op_q == op_gcall) ? `GCALL_RESET : cmd_q;
      3'h2: cur_byte = (op_q == op_read) ? {addr_q, 1'b1} : wdata_q[15:8];
      3'h3: cur_byte = wdata_q[7:0];
      default: cur_byte = 8'hff;
    endcase
  end

  // Every clock pulse and every condition comes from here
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= c_idle;
      op_q <= op_write;
      addr_q <= 7'h00;
      cmd_q <= 8'h00;
      wdata_q <= 16'h0000;
      phase <= 2'h0;
      bit_cnt <= 4'h0;
      idx <= 3'h0;
      n_bytes <= 3'h0;
      txb <= 8'h00;
      shreg <= 8'h00;
      nack <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      ack_err <= 1'b0;
      rdata <= 16'h0000;
      link.ctl_scl_oe <= 1'b0;
      link.ctl_sda_oe <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        c_idle: begin
          if (req) begin
            state <= c_start;
            busy <= 1'b1;
            ack_err <= 1'b0;
            op_q <= op;
            addr_q <= target_addr;
            cmd_q <= cmd_byte;
            wdata_q <= wdata;
            n_bytes <= (op == op_gcall) ? 3'h2 : (op == op_read) ? 3'h5 : 3'h4;
            idx <= 3'h0;
            phase <= 2'h0;
          end
        end
        c_start: begin
          if (tick) begin
            phase <= phase + 2'h1;
            case (phase)
              2'h0: link.ctl_sda_oe <= 1'b0;
              2'h1: link.ctl_scl_oe <= 1'b0;
              2'h2: link.ctl_sda_oe <= 1'b1;
              default: begin
                link.ctl_scl_oe <= 1'b1;
                state <= c_bit;
                bit_cnt <= 4'h0;
                nack <= 1'b0;
                txb <= cur_byte;
              end
            endcase
          end
        end
        c_bit: begin
          if (tick) begin
            phase <= phase + 2'h1;
            case (phase)
              2'h0: begin
                // Data changes only while the clock is low
                if (bit_cnt < `ACK_BIT) begin
                  link.ctl_sda_oe <= is_rx ? 1'b0 : ~txb[7];
                end else begin
                  link.ctl_sda_oe <= is_rx && (idx != n_bytes - 3'h1);
                end
              end
              2'h1: link.ctl_scl_oe <= 1'b0;
              2'h2: begin
                if (bit_cnt < `ACK_BIT) begin
                  shreg <= {shreg[6:0], sda_sync[1]};
                end else if (!is_rx) begin
                  nack <= sda_sync[1];
                end
              end
              default: begin
                link.ctl_scl_oe <= 1'b1;
                if (bit_cnt < `ACK_BIT) begin
                  bit_cnt <= bit_cnt + 4'h1;
                  txb <= {txb[6:0], 1'b0};
                end else begin
                  bit_cnt <= 4'h0;
                  idx <= idx + 3'h1;
                  txb <= 8'h00;
                  if (is_rx) begin
                    rdata <= {rdata[7:0], shreg};
                  end
                  if (nack) begin
                    ack_err <= 1'b1;
                    state <= c_stop;
                  end else if (idx == n_bytes - 3'h1) begin
                    state <= c_stop;
                  end else if (op_q == op_read && idx == `BYTE_CMD) begin
                    state <= c_start;
                  end
                end
              end
            endcase
          end else if (phase == 2'h0 && bit_cnt == 4'h0 && txb == 8'h00 && !is_rx) begin
            txb <= cur_byte;
          end
        end
        default: begin
          if (tick) begin
            phase <= phase + 2'h1;
            case (phase)
              2'h0: link.ctl_sda_oe <= 1'b1;
              2'h1: link.ctl_scl_oe <= 1'b0;
              2'h2: link.ctl_sda_oe <= 1'b0;
              default: begin
                state <= c_idle;
                busy <= 1'b0;
                done <= 1'b1;
              end
            endcase
          end
        end
      endcase
    end
  end
endmodule

// ---- verif/i2c_link_monitor.sv ----
`timescale 1ns/100ps
module i2c_link_monitor (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Resolved wires and enables
  input wire logic scl,
  input wire logic sda,
  input wire logic tgt_sda_oe,
  // Target pulses
  input wire logic update_pulse,
  input wire logic sw_reset
);
  // --------------------------------------------
  // Bus and pulse checks, all on the system clock
  // --------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  chk_update_single: assert property (update_pulse |=> !update_pulse)
    else $error("update pulse longer than one cycle");
  chk_reset_single: assert property (sw_reset |=> !sw_reset)
    else $error("software reset longer than one cycle");
  // Fall ending the ack lies a few cycles back, so the clock is low now and was high 8 cycles ago
  chk_update_after_fall: assert property (update_pulse |-> !scl && $past(scl, 8))
    else $error("update not just after a clock fall");
  chk_reset_at_rise: assert property (sw_reset |-> scl && !$past(scl, 8) && !sda)
    else $error("software reset not at the ack clock rise");
  // Target may only move the data line while the clock is low
  chk_oe_stable_high: assert property (scl && $past(scl) |-> $stable(tgt_sda_oe))
    else $error("target changed data while clock high");
  chk_oe_rise_low: assert property ($rose(tgt_sda_oe) |-> !scl)
    else $error("target drive began with clock high");
  chk_oe_fall_low: assert property ($fell(tgt_sda_oe) |-> !scl)
    else $error("target drive ended with clock high");
  chk_ack_hold_min: assert property ($rose(tgt_sda_oe) |-> tgt_sda_oe [*8])
    else $error("target drive too short");
  chk_stop_release: assert property (scl && $rose(sda) |=> !tgt_sda_oe [*8])
    else $error("target drives after a stop");
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/100ps
module tb import i2c_link_pkg::*; ;
  // --------------------------------------------
  // Stimulus and observed signals
  // --------------------------------------------
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0;
  ctl_op_t op = op_write;
  logic [6:0] target_addr = 7'h00;
  logic [7:0] cmd_byte = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] read_data = 16'h0000;
  logic other_proto_seen = 1'b0;
  logic [1:0] sel_mode = 2'h0;
  logic asel;
  logic busy, done, ack_err, update_pulse, sw_reset;
  logic [15:0] rdata, data_word;
  logic [7:0] command;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  int n_update = 0;
  int n_reset = 0;
  int u;
  int n_scl = 0;
  logic scl_q = 1'b1;

  i2c_link_if link();
  always #10 sys_clk = ~sys_clk;
  // Select pin strapped low, high, to the data wire or to the clock wire
  assign asel = (sel_mode == 2'h0) ? 1'b0 : (sel_mode == 2'h1) ? 1'b1 : (sel_mode == 2'h2) ? link.sda : link.scl;

  i2c_target_port i2c_target_port_inst (.sys_clk(sys_clk), .rst_n(rst_n), .link(link), .addr_select_pin(asel),
    .other_proto_seen(other_proto_seen), .read_data(read_data), .update_pulse(update_pulse), .command(command),
    .data_word(data_word), .sw_reset(sw_reset));
  // Fastest bit rate keeps the run short
  i2c_bus_controller #(.QTR(12)) i2c_bus_controller_inst (.sys_clk(sys_clk), .rst_n(rst_n), .link(link),
    .req(req), .op(op), .target_addr(target_addr), .cmd_byte(cmd_byte), .wdata(wdata), .busy(busy), .done(done),
    .ack_err(ack_err), .rdata(rdata));
  i2c_link_monitor i2c_link_monitor_inst (.sys_clk(sys_clk), .rst_n(rst_n), .scl(link.scl), .sda(link.sda),
    .tgt_sda_oe(link.tgt_sda_oe), .update_pulse(update_pulse), .sw_reset(sw_reset));

  // --------------------------------------------
  // Pulse counters and hang guard
  // --------------------------------------------
  always @(posedge sys_clk) begin
    cyc++;
    if (update_pulse === 1'b1) n_update++;
    if (sw_reset === 1'b1) n_reset++;
    // Rising clock-wire edges, so that frame lengths can be checked
    if (link.scl === 1'b1 && scl_q === 1'b0) n_scl++;
    scl_q = link.scl;
    if (cyc == 60000) begin
      n_mismatch++;
      conclude();
    end
  end

  // --------------------------------------------
  // Tasks
  // --------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One frame: request held for the single idle edge that takes it, then bounded wait for done
  task automatic xfer(input ctl_op_t o, input logic [6:0] a, input logic [7:0] c, input logic [15:0] w);
    int i;
    @(posedge sys_clk);
    #1;
    op = o;
    target_addr = a;
    cmd_byte = c;
    wdata = w;
    req = 1'b1;
    @(posedge sys_clk);
    #1;
    req = 1'b0;
    check({15'h0000, busy}, 16'h0001);
    for (i = 0; i < 6000 && done !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    check({15'h0000, done}, 16'h0001);
    check({15'h0000, busy}, 16'h0000);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [15:0] w, input logic nak);
    int v;
    int s;
    v = n_update;
    s = n_scl;
    xfer(op_write, a, c, w);
    check({15'h0000, ack_err}, {15'h0000, nak});
    // Refused frame: nine clocks then the stop; update frame: 36 clocks then the stop
    check(16'(n_scl - s), nak ? 16'h000a : 16'h0025);
    check(16'(n_update - v), nak ? 16'h0000 : 16'h0001);
    if (!nak) begin
      check({8'h00, command}, {8'h00, c});
      check(data_word, w);
    end
  endtask

  task automatic conclude();
    $display("counts: %0d compared, %0d mismatched", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // --------------------------------------------
  // Test sequence
  // --------------------------------------------
  initial begin
    repeat (4) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    // Every strap, each with a wrong prefix beside it
    for (int m = 0; m < 4; m++) begin
      sel_mode = 2'(m);
      wr({4'h9, 3'(m)}, 8'h30 + 8'(m), 16'hc0a5 ^ 16'(m), 1'b0);
      wr({4'h8, 3'(m)}, 8'h31, 16'h1111, 1'b1);
    end
    $display("test select pin done");
    sel_mode = 2'h1;
    wr(7'h47, 8'h40, 16'h5a5a, 1'b0);
    xfer(op_read, 7'h47, 8'h40, 16'h0000);
    check({15'h0000, ack_err}, 16'h0001);
    wr(7'h78, 8'h41, 16'h2222, 1'b1);
    $display("test broadcast done");
    read_data = 16'hc35a;
    xfer(op_read, {4'h9, 3'h1}, 8'h22, 16'h0000);
    check({15'h0000, ack_err}, 16'h0000);
    check({8'h00, command}, 16'h0022);
    check(rdata, 16'hc35a);
    $display("test read done");
    u = n_reset;
    xfer(op_gcall, 7'h00, 8'h00, 16'h0000);
    check({15'h0000, ack_err}, 16'h0000);
    check(16'(n_reset - u), 16'h0001);
    wr({4'h9, 3'h1}, 8'h55, 16'h0ff0, 1'b0);
    $display("test general call done");
    // Other protocol seen first after reset locks the port out
    @(posedge sys_clk);
    #1;
    rst_n = 1'b0;
    other_proto_seen = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    wr({4'h9, 3'h1}, 8'h56, 16'h1234, 1'b1);
    $display("test protocol lock done");
    conclude();
  end
endmodule
